// file: core/dual_timer_regs.vh
`ifndef DUAL_TIMER_REGS_VH
`define DUAL_TIMER_REGS_VH

// ----------------------------------------------------------------
// Register offsets in data space
// ----------------------------------------------------------------
`define PRESCALER_VALUE_ONE_ADDR 8'hd2
`define DOWN_COUNTER_ONE_ADDR    8'hd3
`define TIMER_CONTROL_ONE_ADDR   8'hd4
`define PRESCALER_VALUE_TWO_ADDR 8'hda
`define DOWN_COUNTER_TWO_ADDR    8'hdb
`define TIMER_CONTROL_TWO_ADDR   8'hdc

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define CTL_ZERO_FLAG_BIT    7
`define CTL_IRQ_ENABLE_BIT   6
`define CTL_ENABLE_OFF_BIT   5
`define CTL_ENABLE_ON_BIT    4
`define CTL_PRESCALER_RUN    3
`define CTL_TAP_HI           2
`define CTL_TAP_LO           0

// ----------------------------------------------------------------
// Reset values and the zero count
// ----------------------------------------------------------------
`define PRESCALER_RESET      7'h7f
`define COUNTER_RESET        8'hff
`define CONTROL_RESET        8'h00
`define COUNTER_ZERO         8'h00

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define OSC_DIVIDE           12
`define OSC_DIV_WIDTH        4

`endif

// file: core/timer_channel.v
`timescale 1ns/10ps

// ----------------------------------------------------------------
// One prescaled down timer channel
// ----------------------------------------------------------------
`include "dual_timer_regs.vh"

module timer_channel (
    // Clock and reset
    input  wire       mclk_i,
    input  wire       nrst_i,
    // Shared controls
    input  wire       tick_i,
    input  wire       enable_i,
    // Register writes
    input  wire       wr_prescaler_i,
    input  wire       wr_counter_i,
    input  wire       wr_control_i,
    input  wire [7:0] wdata_i,
    // State
    output reg  [6:0] prescaler_o,
    output reg  [7:0] counter_o,
    output reg  [7:0] control_o
);

    reg        tap_prev;
    reg        tap_now;
    wire       run;
    wire       tap_rise;
    wire       dec_zero;

    assign run = control_o[`CTL_PRESCALER_RUN] & enable_i;

    // Selected tap level, code 0 is the input tick itself
    always @* begin
        case (control_o[`CTL_TAP_HI:`CTL_TAP_LO])
            3'd0: tap_now = tick_i;
            3'd1: tap_now = prescaler_o[0];
            3'd2: tap_now = prescaler_o[1];
            3'd3: tap_now = prescaler_o[2];
            3'd4: tap_now = prescaler_o[3];
            3'd5: tap_now = prescaler_o[4];
            3'd6: tap_now = prescaler_o[5];
            3'd7: tap_now = prescaler_o[6];
            default: tap_now = 1'b0;
        endcase
    end

    // Code 0 counts every tick; other taps count on rising edge
    assign tap_rise = run & ((control_o[`CTL_TAP_HI:`CTL_TAP_LO] == 3'd0) ? tick_i
                                                          : (tap_now & ~tap_prev));
    assign dec_zero = tap_rise & (counter_o == 8'h01);

    // Edge tracker for the tap
    always @(posedge mclk_i) begin
        if (!nrst_i) begin
            tap_prev <= 1'b1;
        end else begin
            tap_prev <= tap_now;
        end
    end

    // Prescaler
    always @(posedge mclk_i) begin
        if (!nrst_i) begin
            prescaler_o <= `PRESCALER_RESET;
        end else if (!control_o[`CTL_PRESCALER_RUN]) begin
            prescaler_o <= `PRESCALER_RESET;
        end else if (wr_prescaler_i) begin
            prescaler_o <= wdata_i[6:0];
        end else if (run && tick_i) begin
            prescaler_o <= prescaler_o - 7'd1;
        end
    end

    // Down counter, write wins over decrement
    always @(posedge mclk_i) begin
        if (!nrst_i) begin
            counter_o <= `COUNTER_RESET;
        end else if (wr_counter_i) begin
            counter_o <= wdata_i;
        end else if (tap_rise) begin
            counter_o <= counter_o - 8'd1;
        end
    end

    // Control register and zero flag
    always @(posedge mclk_i) begin
        if (!nrst_i) begin
            control_o <= `CONTROL_RESET;
        end else begin
            if (wr_control_i) begin
                control_o <= wdata_i;
            end
            // Hardware set wins over a software clear
            if ((dec_zero && !wr_counter_i) ||
                (wr_counter_i && wdata_i == `COUNTER_ZERO)) begin
                control_o[`CTL_ZERO_FLAG_BIT] <= 1'b1;
            end
        end
    end

endmodule // timer_channel

// file: core/dual_prescaled_down_timer.v
`timescale 1ns/10ps

`include "dual_timer_regs.vh"

module dual_prescaled_down_timer (
    // Clock and reset
    input  wire       mclk_i,
    input  wire       nrst_i,
    // Data-space access
    input  wire [7:0] addr_i,
    input  wire       wr_i,
    input  wire       rd_i,
    input  wire [7:0] wdata_i,
    output reg  [7:0] rdata_o,
    output reg        rd_hit_o,
    // Interrupts and wake
    output reg        irq_one_o,
    output reg        irq_two_o,
    output reg        wake_o
);

    // ------------------------------------------------------------
    // Oscillator divide by twelve
    // ------------------------------------------------------------
    reg  [`OSC_DIV_WIDTH-1:0] osc_div;
    reg                       tick;
    wire                      enable;
    wire [6:0]                psc_one;
    wire [6:0]                psc_two;
    wire [7:0]                cnt_one;
    wire [7:0]                cnt_two;
    wire [7:0]                ctl_one;
    wire [7:0]                ctl_two;
    reg  [7:0]                next_rdata;
    reg                       next_hit;
    reg  [8:0]                next_view;
    // Packed channel state, timer one in the low bits
    wire [13:0]               psc_all;
    wire [15:0]               cnt_all;
    wire [15:0]               ctl_all;
    // Per-timer write strobes and request levels
    wire [1:0]                wr_psc;
    wire [1:0]                wr_cnt;
    wire [1:0]                wr_ctl;
    wire [1:0]                req;
    wire                      div_last;

    // ------------------------------------------------------------
    // Decode functions
    // ------------------------------------------------------------
    // Address decode used for both reads and writes
    function hit;
        input [7:0] a;
        input [7:0] target;
        begin
            hit = (a == target);
        end
    endfunction

    // Prescaler address of timer idx
    function [7:0] psc_addr;
        input integer idx;
        begin
            if (idx == 0) begin
                psc_addr = `PRESCALER_VALUE_ONE_ADDR;
            end else begin
                psc_addr = `PRESCALER_VALUE_TWO_ADDR;
            end
        end
    endfunction

    // Counter address of timer idx
    function [7:0] cnt_addr;
        input integer idx;
        begin
            if (idx == 0) begin
                cnt_addr = `DOWN_COUNTER_ONE_ADDR;
            end else begin
                cnt_addr = `DOWN_COUNTER_TWO_ADDR;
            end
        end
    endfunction

    // Control address of timer idx
    function [7:0] ctl_addr;
        input integer idx;
        begin
            if (idx == 0) begin
                ctl_addr = `TIMER_CONTROL_ONE_ADDR;
            end else begin
                ctl_addr = `TIMER_CONTROL_TWO_ADDR;
            end
        end
    endfunction

    // Request level from a control word, flag and enable together
    function req_of;
        input [7:0] ctl;
        begin
            req_of = ctl[`CTL_ZERO_FLAG_BIT] & ctl[`CTL_IRQ_ENABLE_BIT];
        end
    endfunction

    // Read view of one timer's window, bit 8 is the hit, zero on a miss
    function [8:0] read_timer;
        input [7:0]   a;
        input integer idx;
        input [6:0]   prescaler_value_one;
        input [7:0]   cnt;
        input [7:0]   ctl;
        begin
            read_timer = 9'h000;
            if (hit(a, psc_addr(idx))) begin
                read_timer = {1'b1, 1'b0, prescaler_value_one};
            end else if (hit(a, cnt_addr(idx))) begin
                read_timer = {1'b1, cnt};
            end else if (hit(a, ctl_addr(idx))) begin
                if (idx == 0) begin
                    read_timer = {1'b1, ctl};
                end else begin
                    read_timer = {1'b1, ctl & 8'hcf};
                end
            end
        end
    endfunction

    // ------------------------------------------------------------
    // Tick generator
    // ------------------------------------------------------------
    // Last clock of each group of twelve
    assign div_last = (osc_div == `OSC_DIVIDE - 1);

    // One-cycle tick every twelve clocks
    always @(posedge mclk_i) begin
        if (!nrst_i) begin
            osc_div <= 4'h0;
            tick    <= 1'b0;
        end else if (div_last) begin
            osc_div <= 4'h0;
            tick    <= 1'b1;
        end else begin
            osc_div <= osc_div + 4'h1;
            tick    <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Shared enable
    // ------------------------------------------------------------
    // Shared enable from the first control register only
    assign enable = ctl_one[`CTL_ENABLE_ON_BIT] & ~ctl_one[`CTL_ENABLE_OFF_BIT];

    // ------------------------------------------------------------
    // Timer channels
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < 2; i = i + 1) begin : g_timer
            // Write strobes for this timer's three registers
            assign wr_psc[i] = wr_i & hit(addr_i, psc_addr(i));
            assign wr_cnt[i] = wr_i & hit(addr_i, cnt_addr(i));
            assign wr_ctl[i] = wr_i & hit(addr_i, ctl_addr(i));

            // One channel, same tick and shared enable for both
            timer_channel u_timer (
                .mclk_i         (mclk_i),
                .nrst_i         (nrst_i),
                .tick_i         (tick),
                .enable_i       (enable),
                .wr_prescaler_i (wr_psc[i]),
                .wr_counter_i   (wr_cnt[i]),
                .wr_control_i   (wr_ctl[i]),
                .wdata_i        (wdata_i),
                .prescaler_o    (psc_all[7*i +: 7]),
                .counter_o      (cnt_all[8*i +: 8]),
                .control_o      (ctl_all[8*i +: 8])
            );

            // Request level of this timer
            assign req[i] = req_of(ctl_all[8*i +: 8]);
        end
    endgenerate

    // ------------------------------------------------------------
    // Named views of the packed state
    // ------------------------------------------------------------
    assign psc_one = psc_all[6:0];
    assign psc_two = psc_all[13:7];
    assign cnt_one = cnt_all[7:0];
    assign cnt_two = cnt_all[15:8];
    assign ctl_one = ctl_all[7:0];
    assign ctl_two = ctl_all[15:8];

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    // Windows never overlap, so the two views can be ORed
    always @* begin
        next_view  = read_timer(addr_i, 0, psc_one, cnt_one, ctl_one) |
                     read_timer(addr_i, 1, psc_two, cnt_two, ctl_two);
        next_rdata = next_view[7:0];
        next_hit   = next_view[8];
    end

    // Registered read data, one cycle after the strobe
    always @(posedge mclk_i) begin
        if (!nrst_i) begin
            rdata_o  <= 8'h00;
            rd_hit_o <= 1'b0;
        end else begin
            rdata_o  <= rd_i ? next_rdata : 8'h00;
            rd_hit_o <= rd_i & next_hit;
        end
    end

    // ------------------------------------------------------------
    // Interrupt requests
    // ------------------------------------------------------------
    // Interrupt levels held until software clears the flag or the enable
    always @(posedge mclk_i) begin
        if (!nrst_i) begin
            irq_one_o <= 1'b0;
            irq_two_o <= 1'b0;
            wake_o    <= 1'b0;
        end else begin
            irq_one_o <= req[0];
            irq_two_o <= req[1];
            wake_o    <= |req;
        end
    end

    // ------------------------------------------------------------
    // Operating notes
    // ------------------------------------------------------------
    // Register windows
    //   Timer one: prescaler, counter, control at three adjacent addresses
    //   Timer two: same layout eight addresses higher
    //   Any other address reads 00h with no hit
    //
    // Tick
    //   One mclk_i cycle in twelve carries the tick
    //   Both prescalers run from the one shared tick
    //   The divider restarts from zero after reset
    //
    // Counting
    //   Tap code 0 counts every tick
    //   Other taps count rising edges of one prescaler bit
    //   A tap change can give one extra count on the next edge
    //   The counter wraps from 00h to FFh and keeps counting
    //
    // Shared enable
    //   Only the first control register holds the enable pair
    //   The reserved pair 1x stops both timers like 00
    //   With the pair off, counter and prescaler hold their values
    //   Clearing prescaler-run still forces the prescaler to all ones
    //
    // Zero flag
    //   Set by a decrement to 00h, a write of 00h, or a write of bit 7
    //   A counter write in the cycle of a decrement to 00h wins
    //   Hardware set wins over a software clear in the same cycle
    //   Only software clears it; a stale flag keeps the request up
    //
    // Requests
    //   Requests and wake are levels, one cycle behind the flags
    //   Wake is the OR of both requests
    //   Clearing flag or enable drops the request one cycle later
    //
    // Reads
    //   Read data appears one cycle after the strobe and lasts one cycle
    //   Read data returns to 00h when no read is made
    //   Counter and prescaler read live values, so a read can race a count
    //   Prescaler reads show bit 7 as zero
    //
    // Writes
    //   A write takes effect at the clock edge that samples it
    //   Prescaler writes are dropped while prescaler-run is clear
    //   Control bits 5 and 4 of timer two are stored but never used
    //
    // Reset
    //   Counters FFh, prescalers 7Fh, controls 00h
    //   Request and wake outputs low until the first flag with its enable
    //
    // Limits
    //   No external timer pin, so output mode is the only mode
    //   Longest period is 256 counts of the divide-by-128 tap

endmodule // dual_prescaled_down_timer

// file: test/dual_timer_monitor.sv
`timescale 1ns/10ps

// ----------------------------------------
// Port checker for the dual timer
// ----------------------------------------
module dual_timer_monitor (
    // Clock and reset
    input wire       mclk_i,
    input wire       nrst_i,
    // Data-space access
    input wire [7:0] addr_i,
    input wire       wr_i,
    input wire       rd_i,
    input wire [7:0] wdata_i,
    input wire [7:0] rdata_o,
    input wire       rd_hit_o,
    // Requests
    input wire       irq_one_o,
    input wire       irq_two_o,
    input wire       wake_o
);
    // One clock domain for every check
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);

    AST_HIT_NEEDS_READ: assert property (rd_hit_o |-> $past(rd_i))
        else $error("read hit without a read");
    AST_MAPPED_HIT: assert property (rd_i && addr_i == 8'hd3 |=> rd_hit_o)
        else $error("mapped read gave no hit");
    AST_UNMAPPED: assert property (rd_i && addr_i == 8'h00 |=> !rd_hit_o && rdata_o == 8'h00)
        else $error("unmapped read answered");
    AST_PSC_TOP_ZERO: assert property (rd_i && addr_i[2:0] == 3'h2 |=> !rdata_o[7])
        else $error("prescaler top bit read as one");
    AST_CTL2_UNUSED: assert property (rd_i && addr_i == 8'hdc |=> rdata_o[5:4] == 2'b00)
        else $error("second control bits 5:4 not zero");
    AST_CTL1_STORE: assert property (wr_i && addr_i == 8'hd4 ##2 rd_i && addr_i == 8'hd4
        |=> rdata_o[6:0] == $past(wdata_i[6:0], 3)) else $error("first control readback wrong");
    AST_IRQ_OFF: assert property (wr_i && addr_i == 8'hd4 && !wdata_i[6] |-> ##2 !irq_one_o)
        else $error("request stands with enable off");
    AST_IRQ_ON: assert property (wr_i && addr_i == 8'hd4 && wdata_i[7:6] == 2'b11
        |-> ##[1:2] irq_one_o) else $error("flag and enable raised no request");
    AST_WAKE: assert property (irq_one_o || irq_two_o |-> ##[0:1] wake_o)
        else $error("request gave no wake");

    // Main scenarios reached
    cover property (irq_one_o);
    cover property (irq_two_o);
    cover property (rd_hit_o);
endmodule // dual_timer_monitor

bind dual_prescaled_down_timer dual_timer_monitor mon (.mclk_i(mclk_i), .nrst_i(nrst_i),
    .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
    .rd_hit_o(rd_hit_o), .irq_one_o(irq_one_o), .irq_two_o(irq_two_o), .wake_o(wake_o));

// file: test/testbench.sv
`timescale 1ns/10ps

module testbench;
    reg        mclk_i = 1'b0;
    reg        nrst_i = 1'b0;
    reg  [7:0] addr_i = 8'h00;
    reg        wr_i = 1'b0;
    reg        rd_i = 1'b0;
    reg  [7:0] wdata_i = 8'h00;
    wire [7:0] rdata_o;
    wire       rd_hit_o, irq_one_o, irq_two_o, wake_o;
    integer    errors = 0, samples_checked = 0, cycles = 0, n, k;
    reg  [7:0] v;
    reg        h;

    // Clock and hang guard
    always #25 mclk_i = ~mclk_i;
    always @(posedge mclk_i) begin
        cycles = cycles + 1;
        if (cycles == 9000) begin
            errors = errors + 1;
            print_verdict;
        end
    end

    dual_prescaled_down_timer dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .addr_i(addr_i),
        .wr_i(wr_i), .rd_i(rd_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .rd_hit_o(rd_hit_o),
        .irq_one_o(irq_one_o), .irq_two_o(irq_two_o), .wake_o(wake_o));

    // ----------------------------------------
    // Bus cycles and comparison
    // ----------------------------------------
    task chk(input string nm, input [7:0] seen, input [7:0] exp);
        samples_checked = samples_checked + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        @(negedge mclk_i);
        addr_i = a;
        wdata_i = d;
        wr_i = 1'b1;
        @(negedge mclk_i);
        wr_i = 1'b0;
    endtask
    task rd(input [7:0] a);
        @(negedge mclk_i);
        addr_i = a;
        rd_i = 1'b1;
        @(negedge mclk_i);
        rd_i = 1'b0;
        v = rdata_o;
        h = rd_hit_o;
    endtask
    task rc(input [7:0] a, input [7:0] exp);
        rd(a);
        chk($sformatf("reg_%h", a), v, exp);
    endtask
    task idle(input integer c);
        repeat (c) @(negedge mclk_i);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_reset;
        rc(8'hd2, 8'h7f);
        rc(8'hd3, 8'hff);
        rc(8'hd4, 8'h00);
        rc(8'hda, 8'h7f);
        rc(8'hdb, 8'hff);
        rc(8'hdc, 8'h00);
        rd(8'h00);
        chk("unmapped_hit", {7'h00, h}, 8'h00);
    endtask
    task t_shared_off;
        wr(8'hd3, 8'h10);
        wr(8'hd4, 8'h08);
        rc(8'hd4, 8'h08);
        idle(40);
        rc(8'hd3, 8'h10);
        wr(8'hd4, 8'h38);
        idle(40);
        rc(8'hd3, 8'h10);
    endtask
    task t_run_off;
        wr(8'hd4, 8'h10);
        rc(8'hd2, 8'h7f);
        wr(8'hd2, 8'h20);
        rc(8'hd2, 8'h7f);
        idle(40);
        rc(8'hd3, 8'h10);
    endtask
    task t_psc_load;
        wr(8'hd4, 8'h18);
        wr(8'hd2, 8'h05);
        rd(8'hd2);
        chk("psc_load", v == 8'h05 || v == 8'h04, 8'h01);
    endtask
    task t_taps;
        for (k = 0; k < 4; k = k + 1) begin
            wr(8'hd4, 8'h18 | k[7:0]);
            wr(8'hd3, 8'h80);
            idle(96 << k);
            rd(8'hd3);
            chk($sformatf("tap_%0d", k), v >= 8'h77 && v <= 8'h79, 8'h01);
        end
    endtask
    task t_irq_one;
        wr(8'hd3, 8'h05);
        wr(8'hd4, 8'h58);
        for (n = 0; n < 100 && irq_one_o !== 1'b1; n = n + 1) @(negedge mclk_i);
        chk("irq_delay", n >= 47 && n <= 63, 8'h01);
        rc(8'hd4, 8'hd8);
        chk("wake_one", {7'h00, wake_o}, 8'h01);
        wr(8'hd4, 8'h58);
        idle(1);
        chk("irq_one_clear", {7'h00, irq_one_o}, 8'h00);
        wr(8'hd4, 8'hc0);
        idle(1);
        chk("irq_one_bit7", {7'h00, irq_one_o}, 8'h01);
    endtask
    task t_two;
        wr(8'hdc, 8'h3f);
        rc(8'hdc, 8'h0f);
        wr(8'hdb, 8'h00);
        rc(8'hdc, 8'h8f);
        wr(8'hdc, 8'hc0);
        idle(2);
        chk("irq_two", {7'h00, irq_two_o}, 8'h01);
        chk("wake_two", {7'h00, wake_o}, 8'h01);
    endtask

    task print_verdict;
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Main sequence
    initial begin
        idle(2);
        nrst_i = 1'b1;
        t_reset;
        t_shared_off;
        t_run_off;
        t_psc_load;
        t_taps;
        t_irq_one;
        t_two;
        print_verdict;
    end
endmodule // testbench
